/* core/xbar_ctrl.sv */
// Control path of the 16-nibble crossbar: loading, selection and test forcing.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module xbar_ctrl
  import xbar_pkg::*;
(
  // Clock and reset.
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write channels.
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read channels.
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Control pins and their load clock, from the controller.
  input  wire logic              ctrl_load_clock,
  input  wire logic [PIN_W-1:0]  ctrl_pins_in,
  output var  logic [PIN_W-1:0]  ctrl_pins_out,
  output var  logic              ctrl_pins_oe_n,
  // Internal data bus and switched data outputs.
  input  wire logic [BUS_W-1:0]  internal_bus,
  output var  logic [BUS_W-1:0]  data_out,
  output var  logic [NIBBLES-1:0] data_out_en_n
);

  // ----------------------------------------------------------------------
  // Software registers and their fields
  // ----------------------------------------------------------------------
  logic [31:0]        ctrl_reg;        // Load, readback, test and mux setup.
  logic [31:0]        drive_reg;       // Per-nibble data drive enables.
  wire                load_source_sel  = ctrl_reg[CTRL_SRC_BIT];
  wire                load_bank_sel    = ctrl_reg[CTRL_BANK_BIT];
  wire  [1:0]         nibble_group_addr = ctrl_reg[CTRL_ADDR_LSB +: 2];
  wire                read_bank_sel    = ctrl_reg[CTRL_READ_BIT];
  wire                ctrl_pin_drive_en_n = ctrl_reg[CTRL_DRIVE_BIT];
  wire                load_write_en_n  = ctrl_reg[CTRL_WE_BIT];
  test_mode_t         test_force_sel;
  mux_src_t           mux_control_source_sel;
  wire  [NIBBLES-1:0] data_nibble_drive_en_n = drive_reg[NIBBLES-1:0];

  assign test_force_sel         = test_mode_t'(ctrl_reg[CTRL_TEST_LSB +: 2]);
  assign mux_control_source_sel = mux_src_t'(ctrl_reg[CTRL_MUX_LSB +: 2]);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  // The load clock and the control pins come from the controller, so both
  // pass two flip-flops; the edge detector only looks at the second stage
  // and a third one, never at the first.
  logic [2:0]       load_clk_sync;     // Stage 0 feeds only stage 1.
  logic [PIN_W-1:0] pins_meta;         // First stage of pin data.
  logic [PIN_W-1:0] pins_sync;         // Second stage of pin data.

  // Shift the pin levels into the clock domain.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_clk_sync <= 3'b000;
      pins_meta     <= 16'h0000;
      pins_sync     <= 16'h0000;
    end else begin
      load_clk_sync <= {load_clk_sync[1:0], ctrl_load_clock};
      pins_meta     <= ctrl_pins_in;
      pins_sync     <= pins_meta;
    end
  end

  // A rising load clock edge, seen in the same cycle that the synchronised level rises.
  wire load_edge = load_clk_sync[1] & ~load_clk_sync[2];
  // The write enable gates every load, whatever else is set.
  wire load_fire = load_edge & ~load_write_en_n;

  // ----------------------------------------------------------------------
  // Bank store and load path
  // ----------------------------------------------------------------------
  bank_if bus ();

  bank_store u_store (
    .aclk    (aclk),
    .aresetn (aresetn),
    .port    (bus.store)
  );

  logic [BUS_W-1:0] exch_codes;   // Bus nibbles from the opposite half.
  logic [BUS_W-1:0] pin_codes;    // Pin nibbles spread to their slots.
  logic [BUS_W-1:0] mux_flat;     // Switched nibbles before forcing.
  logic [PIN_W-1:0] readback;     // Addressed nibbles of the read bank.

  assign bus.wr_en   = load_fire;
  assign bus.wr_bank = load_bank_sel;
  assign bus.wr_data = load_source_sel ? exch_codes : pin_codes;

  genvar x;
  generate
    for (x = 0; x < NIBBLES; x++) begin : g_mux
      localparam int EX   = x ^ HALF_XOR;  // Opposite-half partner.
      localparam int LANE = x % GROUPS;    // Group address of nibble x.
      localparam int PGRP = x / GROUPS;    // Pin nibble that feeds it.
      logic [NIB_W-1:0] select_code;       // Active code for this mux.

      // Bus loads take the partner nibble from the other half.
      assign exch_codes[NIB_W*x +: NIB_W] =
        internal_bus[NIB_W*EX +: NIB_W];
      // Pin group g carries nibble a + 4g.
      assign pin_codes[NIB_W*x +: NIB_W] =
        pins_sync[NIB_W*PGRP +: NIB_W];
      // Bus loads hit all sixteen; pin loads only the addressed lane, so
      // four loads with four addresses fill a whole bank.
      assign bus.wr_mask[x] = load_source_sel |
        (nibble_group_addr == 2'(LANE));

      // Pick the code source for this multiplexer.
      assign select_code =
        (mux_control_source_sel == SRC_BANK1) ?
          bus.bank1[NIB_W*x +: NIB_W] :
        (mux_control_source_sel == SRC_BANK2) ?
          bus.bank2[NIB_W*x +: NIB_W] :
        (mux_control_source_sel == SRC_EXCH) ?
          4'(EX) : 4'(x);
      // Code k routes bus bits 4k+3..4k to this output nibble.
      assign mux_flat[NIB_W*x +: NIB_W] =
        internal_bus[{select_code, 2'b00} +: NIB_W];
    end

    for (x = 0; x < GROUPS; x++) begin : g_read
      wire [3:0] slot = {2'(x), nibble_group_addr};  // Nibble a + 4x.
      // The read select picks which bank shows up on the pins.
      assign readback[NIB_W*x +: NIB_W] = read_bank_sel ?
        bus.bank2[{slot, 2'b00} +: NIB_W] :
        bus.bank1[{slot, 2'b00} +: NIB_W];
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Output forcing and enables
  // ----------------------------------------------------------------------
  // Forced levels replace the values only; the enables still decide which
  // pins drive, so a forced level appears only on enabled outputs.
  wire [BUS_W-1:0] next_data_out =
    (test_force_sel == TEST_LOW)  ? 64'h0000_0000_0000_0000 :
    (test_force_sel == TEST_HIGH) ? 64'hffff_ffff_ffff_ffff :
    mux_flat;
  wire [PIN_W-1:0] next_ctrl_out =
    (test_force_sel == TEST_LOW)  ? 16'h0000 :
    (test_force_sel == TEST_HIGH) ? 16'hffff :
    readback;
  // The high-impedance test code overrides every enable.
  wire [NIBBLES-1:0] next_data_en_n =
    (test_force_sel == TEST_HIZ) ? 16'hffff :
    data_nibble_drive_en_n;
  wire next_ctrl_oe_n =
    (test_force_sel == TEST_HIZ) | ctrl_pin_drive_en_n;

  // Register every pin-facing output.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_out       <= 64'h0000_0000_0000_0000;
      data_out_en_n  <= 16'hffff;
      ctrl_pins_out  <= 16'h0000;
      ctrl_pins_oe_n <= 1'b1;
    end else begin
      data_out       <= next_data_out;
      data_out_en_n  <= next_data_en_n;
      ctrl_pins_out  <= next_ctrl_out;
      ctrl_pins_oe_n <= next_ctrl_oe_n;
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------
  // Address and data are taken together in one cycle; waiting for both is
  // legal since the master holds each valid until it is taken.
  wire next_aw_take = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready &
                      ~s_axi_bvalid;
  wire aw_fire      = s_axi_awready & s_axi_awvalid;
  wire wr_ctrl      = aw_fire & (s_axi_awaddr == ADDR_CTRL);
  wire wr_drive     = aw_fire & (s_axi_awaddr == ADDR_DRIVE);
  wire wr_ok        = (s_axi_awaddr == ADDR_CTRL) |
                      (s_axi_awaddr == ADDR_DRIVE);
  wire [31:0] strb_mask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                           {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  wire [31:0] next_ctrl  = ((ctrl_reg & ~strb_mask) |
                            (s_axi_wdata & strb_mask)) & CTRL_WMASK;
  wire [31:0] next_drive = ((drive_reg & ~strb_mask) |
                            (s_axi_wdata & strb_mask)) & DRIVE_WMASK;

  // Write handshake and the response that follows it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= next_aw_take;
      s_axi_wready  <= next_aw_take;
      if (aw_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Software-writable registers, honouring byte strobes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg  <= CTRL_RESET;
      drive_reg <= DRIVE_RESET;
    end else begin
      if (wr_ctrl) ctrl_reg <= next_ctrl;
      if (wr_drive) drive_reg <= next_drive;
    end
  end

  // Read decode; the bank words show the stored codes live.
  wire next_ar_take = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
  wire ar_fire      = s_axi_arready & s_axi_arvalid;
  wire rd_bank      = (s_axi_araddr == ADDR_BANK1_LO) |
                      (s_axi_araddr == ADDR_BANK1_HI) |
                      (s_axi_araddr == ADDR_BANK2_LO) |
                      (s_axi_araddr == ADDR_BANK2_HI);
  wire rd_ok        = rd_bank | (s_axi_araddr == ADDR_CTRL) |
                      (s_axi_araddr == ADDR_DRIVE);
  wire [31:0] next_rdata =
    (s_axi_araddr == ADDR_CTRL)     ? ctrl_reg :
    (s_axi_araddr == ADDR_DRIVE)    ? drive_reg :
    (s_axi_araddr == ADDR_BANK1_LO) ? bus.bank1[31:0] :
    (s_axi_araddr == ADDR_BANK1_HI) ? bus.bank1[63:32] :
    (s_axi_araddr == ADDR_BANK2_LO) ? bus.bank2[31:0] :
    (s_axi_araddr == ADDR_BANK2_HI) ? bus.bank2[63:32] :
    32'h0000_0000;

  // Read handshake; data is captured when the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= next_ar_take;
      if (ar_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= next_rdata;
        s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions and covers
  // ----------------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_LOAD_INHIBIT: assert property (
    load_write_en_n |=> $stable(bus.bank1) && $stable(bus.bank2))
    else $error("Bank changed while write enable was inactive.");

  // Both bank destinations are watched, so a bus load into either bank trips it.
  AST_BUS_LOAD: assert property (
    (load_fire && load_source_sel) |=>
      ($past(load_bank_sel) ? bus.bank2 : bus.bank1) ==
      {$past(internal_bus[31:0]), $past(internal_bus[63:32])})
    else $error("Bus load did not store the exchanged halves.");

  AST_PIN_LOAD: assert property (
    (load_fire && !load_source_sel) |=>
      ($past(load_bank_sel) ?
         bus.bank2[{2'b11, $past(nibble_group_addr), 2'b00} +: 4] :
         bus.bank1[{2'b11, $past(nibble_group_addr), 2'b00} +: 4]) ==
      $past(pins_sync[15:12]))
    else $error("Pin load put the top pin nibble in the wrong slot.");

  AST_PIN_EDGE: assert property (
    ($rose(load_clk_sync[1]) && !load_write_en_n && !load_source_sel &&
     $stable(ctrl_reg)) |=>
      ($past(load_bank_sel) ?
         bus.bank2[{2'b00, $past(nibble_group_addr), 2'b00} +: 4] :
         bus.bank1[{2'b00, $past(nibble_group_addr), 2'b00} +: 4])
      == $past(pins_sync[3:0]))
    else $error("Rising load clock edge did not capture the pins.");

  AST_ECHO: assert property (
    (test_force_sel == TEST_NORMAL && mux_control_source_sel == SRC_ECHO)
      |=> data_out == $past(internal_bus))
    else $error("Echo source did not return each nibble's own input.");

  AST_EXCHANGE: assert property (
    (test_force_sel == TEST_NORMAL && mux_control_source_sel == SRC_EXCH)
      |=> data_out == {$past(internal_bus[31:0]),
                       $past(internal_bus[63:32])})
    else $error("Exchange source did not swap the halves.");

  AST_FORCE_LOW: assert property (
    test_force_sel == TEST_LOW |=> data_out == '0 && ctrl_pins_out == '0)
    else $error("Outputs not forced low.");

  AST_FORCE_HIGH: assert property (
    test_force_sel == TEST_HIGH |=> &data_out && &ctrl_pins_out)
    else $error("Outputs not forced high.");

  AST_HIZ: assert property (
    test_force_sel == TEST_HIZ |=> &data_out_en_n && ctrl_pins_oe_n)
    else $error("Outputs not released in high-impedance test mode.");

  AST_READBACK: assert property (
    (test_force_sel == TEST_NORMAL && !ctrl_pin_drive_en_n) |=>
      !ctrl_pins_oe_n && ctrl_pins_out[3:0] == $past(read_bank_sel ?
        bus.bank2[{2'b00, nibble_group_addr, 2'b00} +: 4] :
        bus.bank1[{2'b00, nibble_group_addr, 2'b00} +: 4]))
    else $error("Readback shows the wrong nibble or is not driven.");

  COV_BUS_LOAD:  cover property (load_fire && load_source_sel);
  COV_PIN_LOAD:  cover property (load_fire && !load_source_sel);
  COV_READBACK:  cover property (!ctrl_pins_oe_n ##1 !ctrl_pins_oe_n);
  COV_AXI_WRITE: cover property (aw_fire ##[1:4] s_axi_bvalid);

endmodule : xbar_ctrl
`default_nettype wire

/* core/xbar_pkg.sv */
// Shared constants and types for the crossbar control nibble loader.
package xbar_pkg;

  // ----------------------------------------------------------------------
  // Geometry of the switch
  // ----------------------------------------------------------------------
  localparam int NIBBLES  = 16;          // Output multiplexers per bank.
  localparam int NIB_W    = 4;           // Bits per select code.
  localparam int BUS_W    = 64;          // Width of the internal data bus.
  localparam int GROUPS   = 4;           // Nibbles moved per pin load.
  localparam int PIN_W    = 16;          // Width of the control pins.
  localparam int HALF_XOR = 8;           // Index flip to the opposite half.

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_DRIVE    = 8'h04;
  localparam logic [7:0]  ADDR_BANK1_LO = 8'h08;
  localparam logic [7:0]  ADDR_BANK1_HI = 8'h0c;
  localparam logic [7:0]  ADDR_BANK2_LO = 8'h10;
  localparam logic [7:0]  ADDR_BANK2_HI = 8'h14;

  // ----------------------------------------------------------------------
  // Control register fields and reset values
  // ----------------------------------------------------------------------
  localparam int          CTRL_SRC_BIT   = 0;
  localparam int          CTRL_BANK_BIT  = 1;
  localparam int          CTRL_ADDR_LSB  = 2;
  localparam int          CTRL_READ_BIT  = 4;
  localparam int          CTRL_DRIVE_BIT = 5;
  localparam int          CTRL_WE_BIT    = 6;
  localparam int          CTRL_TEST_LSB  = 8;
  localparam int          CTRL_MUX_LSB   = 10;
  localparam logic [31:0] CTRL_WMASK     = 32'h0000_0f7f;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0360;
  localparam logic [31:0] DRIVE_WMASK    = 32'h0000_ffff;
  localparam logic [31:0] DRIVE_RESET    = 32'h0000_ffff;

  // ----------------------------------------------------------------------
  // Bus answers and mode encodings
  // ----------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    SRC_BANK1 = 2'b00,
    SRC_BANK2 = 2'b01,
    SRC_EXCH  = 2'b10,
    SRC_ECHO  = 2'b11
  } mux_src_t;

  typedef enum logic [1:0] {
    TEST_LOW    = 2'b00,
    TEST_HIGH   = 2'b01,
    TEST_HIZ    = 2'b10,
    TEST_NORMAL = 2'b11
  } test_mode_t;

endpackage : xbar_pkg

/* core/bank_if.sv */
// Write and read signals between the loader and its two select-code banks.
`timescale 1ns/1ps
`default_nettype none
interface bank_if;
  logic        wr_en;    // Load strobe, one cycle.
  logic        wr_bank;  // Low writes bank 1, high writes bank 2.
  logic [15:0] wr_mask;  // One bit per nibble to be written.
  logic [63:0] wr_data;  // New select codes, nibble x at bits 4x+3..4x.
  logic [63:0] bank1;    // Stored codes of bank 1.
  logic [63:0] bank2;    // Stored codes of bank 2.

  modport ctl   (output wr_en, wr_bank, wr_mask, wr_data,
                 input  bank1, bank2);
  modport store (input  wr_en, wr_bank, wr_mask, wr_data,
                 output bank1, bank2);
endinterface : bank_if
`default_nettype wire

/* core/bank_store.sv */
// Two banks of sixteen select-code nibbles held in flip-flops.
`timescale 1ns/1ps
`default_nettype none
module bank_store
  import xbar_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Loader side.
  bank_if.store    port
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  // Each nibble is its own enable group so that a pin load touches only
  // the four nibbles that its address picks.
  genvar x;
  generate
    for (x = 0; x < NIBBLES; x++) begin : g_nib
      // Four rising-edge flip-flops per nibble and bank.
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          port.bank1[NIB_W*x +: NIB_W] <= 4'h0;
          port.bank2[NIB_W*x +: NIB_W] <= 4'h0;
        end else if (port.wr_en && port.wr_mask[x]) begin
          if (port.wr_bank) begin
            port.bank2[NIB_W*x +: NIB_W] <= port.wr_data[NIB_W*x +: NIB_W];
          end else begin
            port.bank1[NIB_W*x +: NIB_W] <= port.wr_data[NIB_W*x +: NIB_W];
          end
        end
      end
    end
  endgenerate

endmodule : bank_store
`default_nettype wire

/* dv/ctrl_partner.sv */
// Controller model that drives the control pins and the load clock.
`timescale 1ns/1ps
`default_nettype none
module ctrl_partner
  import xbar_pkg::*;
(
  // Clock and the device's pin drive.
  input  wire logic             aclk,
  input  wire logic [PIN_W-1:0] dev_pins,
  input  wire logic             dev_oe_n,
  // Controller outputs.
  output var  logic             load_clk,
  output var  logic [PIN_W-1:0] pins
);
  logic [PIN_W-1:0] drv = '0; // Value the controller offers.
  logic             on  = 0;  // High while the controller drives.
  initial load_clk = 1'b0;
  // Undriven pins show the inverse of the last value, never a stale copy.
  assign pins = !dev_oe_n ? dev_pins : on ? drv : ~drv;
  // One load: set up, clock high, then clock low and the pins released on the same edge.
  task automatic load(input logic [PIN_W-1:0] v);
    drv <= v;
    on <= 1'b1;
    repeat (4) @(posedge aclk);
    load_clk <= 1'b1;
    repeat (4) @(posedge aclk);
    load_clk <= 1'b0;
    on <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask : load
endmodule : ctrl_partner
`default_nettype wire

/* dv/tb_top.sv */
// Self-checking bench for the crossbar control loader.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import xbar_pkg::*;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, ctrl_pins_oe_n, ctrl_load_clock;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] ctrl_pins_in, ctrl_pins_out, data_out_en_n, pw;
  logic [63:0] internal_bus = '0, data_out, e2, ex;
  logic [3:0] c;
  int num_errors = 0, checked = 0, cyc = 0;
  always #12.5 aclk = ~aclk;
  xbar_ctrl xbar_ctrl_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ctrl_load_clock,
    .ctrl_pins_in, .ctrl_pins_out, .ctrl_pins_oe_n, .internal_bus,
    .data_out, .data_out_en_n);
  ctrl_partner ctrl_partner_inst (.aclk, .dev_pins(ctrl_pins_out),
    .dev_oe_n(ctrl_pins_oe_n), .load_clk(ctrl_load_clock),
    .pins(ctrl_pins_in));
  // Compare one value and count it.
  task automatic ck(input logic [63:0] s, input logic [63:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : ck
  // One write; the response is judged here.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // Each channel is released at the edge that takes it.
    fork
      begin
        do @(posedge aclk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (s_axi_wready !== 1'b1);
        s_axi_wvalid <= 1'b0;
      end
    join
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    s_axi_bready <= 1'b0;
    ck(s_axi_bresp, er);
  endtask : wr
  // One read; data and response are judged here.
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    ck(s_axi_rdata, e);
    ck(s_axi_rresp, er);
  endtask : rd
  // Let registered outputs settle before looking at them.
  task automatic w3();
    repeat (3) @(posedge aclk);
    #1;
  endtask : w3
  // Reset values, an unmapped read and a read-only write.
  task automatic t_regs();
    rd(ADDR_CTRL, CTRL_RESET, RESP_OKAY);
    rd(ADDR_DRIVE, DRIVE_RESET, RESP_OKAY);
    rd(8'h18, 32'h0, RESP_SLVERR);
    wr(ADDR_BANK1_LO, 32'h1, RESP_SLVERR);
    rd(ADDR_BANK1_LO, 32'h0, RESP_OKAY);
  endtask : t_regs
  // Fill bank 1 from the pins with code 15-x, four loads; then an inhibit.
  task automatic t_pins();
    for (int a = 0; a < 4; a++) begin
      wr(ADDR_CTRL, 32'h320 | (a << 2), RESP_OKAY);
      for (int j = 0; j < 4; j++) pw[4*j+:4] = 4'(15 - (a + 4 * j));
      ctrl_partner_inst.load(pw);
    end
    wr(ADDR_CTRL, 32'h360, RESP_OKAY);
    ctrl_partner_inst.load(16'h5a5a);
    rd(ADDR_BANK1_LO, 32'h89abcdef, RESP_OKAY);
    rd(ADDR_BANK1_HI, 32'h01234567, RESP_OKAY);
  endtask : t_pins
  // Bus load into bank 2, then read one group back on the pins.
  task automatic t_bus();
    wr(ADDR_CTRL, 32'h323, RESP_OKAY);
    internal_bus <= 64'h0f1e_2d3c_4b5a_6978;
    ctrl_partner_inst.load(16'h0);
    e2 = {internal_bus[31:0], internal_bus[63:32]};
    rd(ADDR_BANK2_LO, e2[31:0], RESP_OKAY);
    rd(ADDR_BANK2_HI, e2[63:32], RESP_OKAY);
    wr(ADDR_CTRL, 32'h354, RESP_OKAY);
    w3();
    for (int j = 0; j < 4; j++) pw[4*j+:4] = e2[4*(1+4*j)+:4];
    ck(ctrl_pins_out, pw);
    ck(ctrl_pins_oe_n, 1'b0);
  endtask : t_bus
  // Every control source drives the outputs.
  task automatic t_mux();
    wr(ADDR_DRIVE, 32'h0, RESP_OKAY);
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_CTRL, 32'h360 | (s << 10), RESP_OKAY);
      w3();
      for (int x = 0; x < 16; x++) begin
        c = s == 0 ? 4'(15 - x) : s == 1 ? e2[4*x+:4] :
            s == 2 ? 4'(x ^ 8) : 4'(x);
        ex[4*x+:4] = internal_bus[4*c+:4];
      end
      ck(data_out, ex);
      ck(data_out_en_n, 16'h0);
    end
  endtask : t_mux
  // Forced low, forced high and floating outputs.
  task automatic t_test();
    for (int t = 0; t < 3; t++) begin
      wr(ADDR_CTRL, 32'h40 | (t << 8), RESP_OKAY);
      w3();
      if (t == 2) begin
        ck(data_out_en_n, 16'hffff);
        ck(ctrl_pins_oe_n, 1'b1);
      end else begin
        ck(data_out, {64{t[0]}});
        ck(ctrl_pins_out, {16{t[0]}});
      end
    end
  endtask : t_test
  // Report and end the run.
  task automatic summarize();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  // A hang ends the run as a failure.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_pins();
    t_bus();
    t_mux();
    t_test();
    summarize();
  end
endmodule : tb_top
`default_nettype wire
